// file: testbench.sv
`timescale 1ns/100ps
module testbench;
    logic sys_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, go = 1'b0;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, r;
    logic pready, pslverr, sample_vld, live_fail_out, fail_verdict, ready_out;
    logic [15:0] x_in, y_in;
    logic [9:0] din = 10'h050;
    logic [12:0] dout;
    logic [5:0] limit_switch_outputs;
    int fail_count = 0, cmp_count = 0;
    xyce_top DUT (.sys_clk(sys_clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sample_vld(sample_vld), .x_in(x_in), .y_in(y_in), .din(din), .dout(dout),
        .limit_switch_outputs(limit_switch_outputs), .live_fail_out(live_fail_out),
        .fail_verdict(fail_verdict), .ready_out(ready_out));
    xyce_sensor sensor (.clk(sys_clk), .go(go), .vld(sample_vld), .x(x_in), .y(y_in));
    // 50 mhz system clock
    always #10 sys_clk = ~sys_clk;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // apb transfer: request held until pready is sampled high, read data taken there
    task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {16'h0, a};
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        r = prdata;
        chk({31'h0, pready}, 32'h1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask : apb
    task automatic await(input logic v);
        int n;
        n = 0;
        while (ready_out !== v && n < 100) begin
            @(posedge sys_clk);
            n++;
        end
        chk({31'h0, ready_out}, {31'h0, v});
    endtask : await
    // one measurement: external start, one sweep, external stop, then the verdict
    task automatic meas(input logic [31:0] wins, input logic bad);
        apb(1'b1, 16'(xyce_pkg::A_WINS), wins);
        apb(1'b1, 16'(xyce_pkg::A_CTRL), 32'h1);
        din[0] <= 1'b1;
        await(1'b0);
        chk({31'h0, live_fail_out}, 32'h0);
        go <= 1'b1;
        @(posedge sys_clk);
        go <= 1'b0;
        repeat (40) @(posedge sys_clk);
        chk({31'h0, live_fail_out}, {31'h0, bad & wins[9]});
        // controller ends the stroke 40 cycles after go, once the live signal has been checked
        din[0] <= 1'b0;
        await(1'b1);
        chk({31'h0, fail_verdict}, {31'h0, bad});
    endtask : meas
    task automatic conclude();
        $display("comparisons %0d, mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : conclude
    // watchdog cuts a hang short
    initial begin
        #2000000;
        fail_count++;
        conclude();
    end
    // main sequence
    initial begin
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (3) @(posedge sys_clk);
        chk({31'h0, ready_out}, 32'h1);
        chk({28'h0, dout[12:9]}, 32'h5);
        apb(1'b0, 16'h007c, 32'h0);
        chk(r, 32'h0);
        apb(1'b1, 16'(xyce_pkg::A_SAMP), 32'h8000_0001);
        apb(1'b1, 16'(xyce_pkg::A_WINX), 32'h012c_0064);
        apb(1'b1, 16'(xyce_pkg::A_WINY), 32'h03e8_0000);
        apb(1'b1, 16'(xyce_pkg::A_LIM0), 32'h0064_0000);
        apb(1'b1, 16'(xyce_pkg::A_LIM0) + 16'h4, 32'h0064_0003);
        apb(1'b1, 16'(xyce_pkg::A_LIM0) + 16'h8, 32'h0258_0001);
        meas(32'h0000_0621, 1'b0);
        apb(1'b0, 16'(xyce_pkg::A_WMM), 32'h0);
        chk(r, 32'h01f4_01f4);
        apb(1'b0, 16'h1000, 32'h0);
        chk(r, 32'h0019_01f4);
        chk({26'h0, limit_switch_outputs}, 32'h39);
        meas(32'h0000_0681, 1'b1);
        meas(32'h0000_0600, 1'b1);
        meas(32'h0000_0621, 1'b0);
        apb(1'b1, 16'(xyce_pkg::A_ENVX), 32'h0190_0000);
        apb(1'b1, 16'(xyce_pkg::A_ENV), 32'h01f4_0011);
        meas(32'h0000_0000, 1'b0);
        apb(1'b1, 16'(xyce_pkg::A_ENV), 32'h0100_0011);
        meas(32'h0000_0000, 1'b1);
        apb(1'b1, 16'(xyce_pkg::A_ENV), 32'h0000_0000);
        apb(1'b1, 16'(xyce_pkg::A_THR0), 32'h00c8_0002);
        meas(32'h0000_0000, 1'b0);
        apb(1'b1, 16'(xyce_pkg::A_THR0), 32'h0190_0002);
        meas(32'h0000_0000, 1'b1);
        conclude();
    end
endmodule : testbench

// file: xyce_mem.sv
`timescale 1ns/100ps
// curve memory, registered read port
module xyce_mem #(
    parameter int AW = 10,
    parameter int W = 32
) (
    input wire logic clk, // clock
    input wire logic we, // write strobe
    input wire logic [AW-1:0] waddr, // write address
    input wire logic [W-1:0] wdata, // write data
    input wire logic [AW-1:0] raddr, // read address
    output logic [W-1:0] rdata // registered read data
);
    logic [W-1:0] mem [2**AW];
    // single write, single registered read
    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule : xyce_mem

// file: xyce_pkg.sv
// Contract
// RULE_01 - store every synchronous x/y sample pair in curve memory while recording; code stores only the first pair and pairs meeting a RULE_14 criterion
// RULE_02 - evaluate right after recording; signal ready only when evaluation ends
// RULE_03 - fail verdict if any configured element fails, otherwise pass verdict
// RULE_04 - window passes only on entry via allowed side and exit via allowed side
// RULE_05 - live fail output rises during recording when the assigned window is violated
// RULE_06 - support windows with no allowed sides and windows where curve must end inside
// RULE_07 - each window records entry, exit, minimum and maximum points inside
// RULE_08 - trapezium forms: fixed x bounds with sloped y edges, or fixed y bounds
// RULE_09 - trapezium allows one entry side, checks crossings, computes entry and exit
// RULE_10 - up to two thresholds, x or y type, locate and check curve crossing
// RULE_11 - one envelope element passes only when every point is inside the y band
// RULE_12 - reject an envelope configuration that spans the curve turning point
// RULE_13 - sixteen program configurations, selected by the controlling party; code keeps one register set and only shows the selection on dout
// RULE_14 - store a point when time, x delta or y delta criterion is met
// RULE_15 - start on external input, or x/y rising above or falling below a level
// RULE_16 - stop on external input, level crossing, timeout or sample count
// RULE_17 - six limit outputs, each with channel, level and polarity choice
// RULE_18 - limit outputs update in standby and measuring, within 3 ms
// RULE_19 - controller may abort the process early using the live fail output
// RULE_20 - ten discrete inputs and thirteen discrete outputs, some user assignable; code assigns none, dout bits are fixed and only din[0] and din[7:4] are read
// RULE_21 - limit outputs compare assigned channel to level before polarity inversion
// RULE_22 - live fail output and window state clear at each measurement start
package xyce_pkg;
    localparam int DW = 16;
    localparam int AW = 10;
    localparam int N_LIMIT = 6;
    localparam int N_PROG = 16;
    localparam int N_DIN = 10;
    localparam int N_DOUT = 13;
    localparam int CLK_HZ = 50000000;
    localparam int LIMIT_MS = 3;
    localparam int LIMIT_CYC = (CLK_HZ / 1000) * LIMIT_MS;
    // register byte offsets
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_STAT = 8'h04;
    localparam logic [7:0] A_START = 8'h08;
    localparam logic [7:0] A_STOP = 8'h0c;
    localparam logic [7:0] A_SAMP = 8'h10;
    localparam logic [7:0] A_TMO = 8'h14;
    localparam logic [7:0] A_WINX = 8'h18;
    localparam logic [7:0] A_WINY = 8'h1c;
    localparam logic [7:0] A_WINS = 8'h20;
    localparam logic [7:0] A_WENT = 8'h24;
    localparam logic [7:0] A_WEXT = 8'h28;
    localparam logic [7:0] A_WMM = 8'h2c;
    localparam logic [7:0] A_TRAP = 8'h30;
    localparam logic [7:0] A_TRAPB = 8'h34;
    localparam logic [7:0] A_TRES = 8'h38;
    localparam logic [7:0] A_THR0 = 8'h3c;
    localparam logic [7:0] A_THR1 = 8'h40;
    localparam logic [7:0] A_THRES = 8'h44;
    localparam logic [7:0] A_ENV = 8'h48;
    localparam logic [7:0] A_ENVX = 8'h4c;
    localparam logic [7:0] A_LIM0 = 8'h50;
    localparam logic [7:0] A_CNT = 8'h68;
    localparam logic [7:0] A_MEM = 8'h6c;
    // window side bits: left, right, bottom, top
    localparam int S_L = 0;
    localparam int S_R = 1;
    localparam int S_B = 2;
    localparam int S_T = 3;
    // start/stop source codes
    localparam logic [2:0] C_EXT = 3'h0;
    localparam logic [2:0] C_XUP = 3'h1;
    localparam logic [2:0] C_XDN = 3'h2;
    localparam logic [2:0] C_YUP = 3'h3;
    localparam logic [2:0] C_YDN = 3'h4;
    localparam logic [2:0] C_TMO = 3'h5;
    localparam logic [2:0] C_CNT = 3'h6;
    typedef enum {ST_IDLE, ST_REC, ST_EVAL} xyce_st_t;
endpackage : xyce_pkg

// file: xyce_sensor.sv
`timescale 1ns/100ps
// x/y channel pair: after go, sweeps x upward at constant y, one pair every 4 cycles
module xyce_sensor #(
    parameter int N = 8
) (
    input wire logic clk, // clock
    input wire logic go, // start a sweep
    output logic vld, // sample strobe
    output logic [15:0] x, // channel x
    output logic [15:0] y // channel y
);
    int cnt = N;
    int gap = 0;
    initial begin
        vld = 1'b0;
        x = 16'h0000;
        y = 16'h0000;
    end
    // lines are inverted after each pair so stale data is never mistaken for a sample
    always @(posedge clk) begin
        vld <= 1'b0;
        if (vld) begin
            x <= ~x;
            y <= ~y;
        end
        if (go) begin
            cnt <= 0;
            gap <= 0;
        end else if (cnt < N) begin
            gap <= gap + 1;
            if (gap == 3) begin
                vld <= 1'b1;
                x <= 16'(25 + 50 * cnt);
                y <= 16'h01f4;
                cnt <= cnt + 1;
                gap <= 0;
            end
        end
    end
endmodule : xyce_sensor

// file: xyce_top.sv
`timescale 1ns/100ps
module xyce_top #(
    parameter int LIMIT_CYC = xyce_pkg::LIMIT_CYC
) (
    input wire logic sys_clk, // system clock
    input wire logic rst, // sync reset
    input wire logic [31:0] paddr, // apb address
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error
    input wire logic sample_vld, // new synchronous x/y pair
    input wire logic [15:0] x_in, // channel x
    input wire logic [15:0] y_in, // channel y
    input wire logic [9:0] din, // discrete inputs, bit0 start/stop, 4..7 program
    output logic [12:0] dout, // discrete outputs
    output logic [5:0] limit_switch_outputs, // real-time switching signals
    output logic live_fail_out, // live window fail
    output logic fail_verdict, // global fail
    output logic ready_out // ready for next measurement
);
    localparam int DW = xyce_pkg::DW;
    localparam int AW = xyce_pkg::AW;
    typedef struct packed {
        xyce_pkg::xyce_st_t st;
        logic [31:0] ctrl, start, stop, samp, tmo, winx, winy, wins;
        logic [31:0] trap, trapb, thr0, thr1, env, envx;
        logic [5:0][31:0] lim;
        logic [DW-1:0] lx, ly, px, py; // last stored point, copied into both pairs
        logic [15:0] dt;
        logic [31:0] tcnt;
        logic [AW:0] cnt;
        logic first, in_w, win_ent, win_bad, ended_in;
        logic [3:0] ent_side;
        logic [31:0] went, wext;
        logic [DW-1:0] wmin, wmax;
        logic t_ent, t_bad;
        logic [31:0] tres;
        logic [1:0] th_hit;
        logic [1:0][DW-1:0] th_at;
        logic env_bad, env_turn, xdir_dn;
        logic fail, rdy, live;
        logic [5:0] lsw;
        logic [31:0] rd;
        logic rdy_bus;
    } xyce_s_t;
    xyce_s_t s_q, s_d;
    logic [31:0] mem_rd;
    logic mem_we;
    logic [AW-1:0] mem_ra;

    function automatic logic [3:0] side_of(input logic [DW-1:0] x, y, input logic [31:0] bx,
                                           input logic [31:0] by);
        side_of = {y > by[31:16], y < by[15:0], x > bx[31:16], x < bx[15:0]};
    endfunction : side_of

    function automatic logic in_box(input logic [DW-1:0] x, y, input logic [31:0] bx,
                                    input logic [31:0] by);
        in_box = side_of(x, y, bx, by) == 4'h0;
    endfunction : in_box

    // curve memory holds x in high half, y in low half
    xyce_mem #(.AW(AW), .W(32)) u_mem (
        .clk(sys_clk),
        .we(mem_we),
        .waddr(s_q.cnt[AW-1:0]),
        .wdata({x_in, y_in}),
        .raddr(mem_ra),
        .rdata(mem_rd)
    );

    logic store, start_hit, stop_hit, acc, bus_wr;
    logic [DW-1:0] ddx, ddy, tlo, thi, ty;
    logic [3:0] ps, cs;
    logic [3:0] prog;
    assign prog = s_q.ctrl[7:4] | din[7:4]; // program select, shown on dout only, one register set RULE_13
    assign acc = psel && penable && !s_q.rdy_bus;
    // writes commit on the edge that shows pready high, never one edge ahead of it
    assign bus_wr = psel && penable && pwrite && s_q.rdy_bus;
    assign mem_ra = paddr[AW+1:2];
    assign ddx = (x_in > s_q.lx) ? x_in - s_q.lx : s_q.lx - x_in;
    assign ddy = (y_in > s_q.ly) ? y_in - s_q.ly : s_q.ly - y_in;
    // compression: any enabled criterion stores a point RULE_14
    assign store = s_q.st == xyce_pkg::ST_REC && sample_vld && (s_q.first
        || (s_q.samp[31] && s_q.dt >= s_q.samp[15:0])
        || (s_q.samp[30] && ddx >= {4'h0, s_q.samp[29:18]})
        || (s_q.samp[29] && ddy >= {6'h0, s_q.samp[25:16]}));
    assign mem_we = store && !s_q.cnt[AW]; // RULE_01
    // start conditions RULE_15
    always_comb begin
        case (s_q.start[2:0])
            xyce_pkg::C_EXT: start_hit = din[0];
            xyce_pkg::C_XUP: start_hit = sample_vld && x_in > s_q.start[31:16];
            xyce_pkg::C_XDN: start_hit = sample_vld && x_in < s_q.start[31:16];
            xyce_pkg::C_YUP: start_hit = sample_vld && y_in > s_q.start[31:16];
            xyce_pkg::C_YDN: start_hit = sample_vld && y_in < s_q.start[31:16];
            default: start_hit = 1'b0;
        endcase
    end
    // stop conditions RULE_16
    always_comb begin
        case (s_q.stop[2:0])
            xyce_pkg::C_EXT: stop_hit = !din[0];
            xyce_pkg::C_XUP: stop_hit = sample_vld && x_in > s_q.stop[31:16];
            xyce_pkg::C_XDN: stop_hit = sample_vld && x_in < s_q.stop[31:16];
            xyce_pkg::C_YUP: stop_hit = sample_vld && y_in > s_q.stop[31:16];
            xyce_pkg::C_YDN: stop_hit = sample_vld && y_in < s_q.stop[31:16];
            xyce_pkg::C_TMO: stop_hit = s_q.tcnt >= s_q.tmo;
            xyce_pkg::C_CNT: stop_hit = {21'h0, s_q.cnt} >= s_q.stop[31:16] || s_q.cnt[AW];
            default: stop_hit = s_q.cnt[AW];
        endcase
    end
    // trapezium bounds: type x slopes y edges over x, type y fixed y RULE_08
    always_comb begin
        if (!s_q.trap[1]) begin
            tlo = s_q.trapb[15:0] + DW'((x_in - s_q.trap[31:16]) >> s_q.trap[7:4]);
            thi = s_q.trapb[31:16] + DW'((x_in - s_q.trap[31:16]) >> s_q.trap[7:4]);
            ty = y_in;
        end else begin
            tlo = s_q.trapb[15:0];
            thi = s_q.trapb[31:16];
            ty = y_in;
        end
    end
    assign ps = side_of(s_q.px, s_q.py, s_q.winx, s_q.winy);
    assign cs = side_of(x_in, y_in, s_q.winx, s_q.winy);

    // main next-state process
    always_comb begin
        s_d = s_q;
        s_d.rdy_bus = acc;
        if (bus_wr) begin
            case (paddr[7:0])
                xyce_pkg::A_CTRL: s_d.ctrl = pwdata;
                xyce_pkg::A_START: s_d.start = pwdata;
                xyce_pkg::A_STOP: s_d.stop = pwdata;
                xyce_pkg::A_SAMP: s_d.samp = pwdata;
                xyce_pkg::A_TMO: s_d.tmo = pwdata;
                xyce_pkg::A_WINX: s_d.winx = pwdata;
                xyce_pkg::A_WINY: s_d.winy = pwdata;
                xyce_pkg::A_WINS: s_d.wins = pwdata;
                xyce_pkg::A_TRAP: s_d.trap = pwdata;
                xyce_pkg::A_TRAPB: s_d.trapb = pwdata;
                xyce_pkg::A_THR0: s_d.thr0 = pwdata;
                xyce_pkg::A_THR1: s_d.thr1 = pwdata;
                xyce_pkg::A_ENV: s_d.env = pwdata;
                xyce_pkg::A_ENVX: s_d.envx = pwdata;
                default: begin
                    for (int i = 0; i < xyce_pkg::N_LIMIT; i++) begin
                        if (paddr[7:0] == xyce_pkg::A_LIM0 + 8'(4 * i)) begin
                            s_d.lim[i] = pwdata;
                        end
                    end
                end
            endcase
        end
        // read mux, memory window wherever address bit 12 is set, from 0x1000
        case (paddr[7:0])
            xyce_pkg::A_CTRL: s_d.rd = s_q.ctrl;
            xyce_pkg::A_STAT: s_d.rd = {22'h0, s_q.lsw, s_q.live, s_q.fail, s_q.rdy,
                                        s_q.st == xyce_pkg::ST_REC};
            xyce_pkg::A_WENT: s_d.rd = s_q.went;
            xyce_pkg::A_WEXT: s_d.rd = s_q.wext;
            xyce_pkg::A_WMM: s_d.rd = {s_q.wmax, s_q.wmin};
            xyce_pkg::A_TRES: s_d.rd = s_q.tres;
            xyce_pkg::A_THRES: s_d.rd = {s_q.th_at[1][14:0], s_q.th_at[0][14:0], s_q.th_hit};
            xyce_pkg::A_CNT: s_d.rd = {21'h0, s_q.cnt};
            default: s_d.rd = 32'h0;
        endcase
        if (paddr[12]) begin
            s_d.rd = mem_rd;
        end
        // limit outputs follow every sample in any state RULE_18
        if (sample_vld) begin
            for (int i = 0; i < xyce_pkg::N_LIMIT; i++) begin
                // compare before polarity inversion RULE_21
                s_d.lsw[i] = ((s_q.lim[i][0] ? y_in : x_in) > s_q.lim[i][31:16])
                             ^ s_q.lim[i][1]; // RULE_17
            end
        end
        case (s_q.st)
            xyce_pkg::ST_IDLE: begin
                if (start_hit && s_q.ctrl[0]) begin
                    s_d.st = xyce_pkg::ST_REC;
                    s_d.rdy = 1'b0;
                    s_d.cnt = '0;
                    s_d.tcnt = '0;
                    s_d.first = 1'b1;
                    s_d.live = 1'b0; // RULE_22
                    s_d.in_w = 1'b0;
                    s_d.win_ent = 1'b0;
                    s_d.win_bad = 1'b0;
                    s_d.wmin = '1;
                    s_d.wmax = '0;
                    s_d.t_ent = 1'b0;
                    s_d.t_bad = 1'b0;
                    s_d.th_hit = '0;
                    s_d.env_bad = 1'b0;
                    s_d.env_turn = 1'b0;
                    s_d.xdir_dn = 1'b0;
                end
            end
            xyce_pkg::ST_REC: begin
                s_d.tcnt = s_q.tcnt + 32'h1;
                if (sample_vld) begin
                    s_d.dt = s_q.dt + 16'h1;
                end
                if (store) begin
                    s_d.first = 1'b0;
                    s_d.dt = '0;
                    s_d.lx = x_in;
                    s_d.ly = y_in;
                    s_d.px = x_in;
                    s_d.py = y_in;
                    if (!s_q.cnt[AW]) begin
                        s_d.cnt = s_q.cnt + 1'b1;
                    end
                    // window tracking RULE_07
                    if (in_box(x_in, y_in, s_q.winx, s_q.winy)) begin
                        if (!s_q.in_w) begin
                            s_d.in_w = 1'b1;
                            s_d.win_ent = 1'b1;
                            s_d.went = {x_in, y_in};
                            s_d.ent_side = ps;
                            // entry side must be allowed RULE_04 RULE_06
                            if (s_q.first || (ps & s_q.wins[3:0]) == 4'h0) begin
                                s_d.win_bad = 1'b1;
                            end
                        end
                        if (y_in < s_q.wmin) begin
                            s_d.wmin = y_in;
                        end
                        if (y_in > s_q.wmax) begin
                            s_d.wmax = y_in;
                        end
                    end else if (s_q.in_w) begin
                        s_d.in_w = 1'b0;
                        s_d.wext = {x_in, y_in};
                        if ((cs & s_q.wins[7:4]) == 4'h0 || s_q.wins[8]) begin // RULE_04
                            s_d.win_bad = 1'b1;
                        end
                    end
                    // trapezium, single entry side at low bound RULE_09
                    if (s_q.trap[0]) begin
                        if (!s_q.t_ent && ((!s_q.trap[1] && x_in >= s_q.trap[31:16])
                            || (s_q.trap[1] && ty >= tlo))) begin
                            s_d.t_ent = 1'b1;
                            s_d.tres[15:0] = s_q.trap[1] ? x_in : y_in;
                            if (ty < tlo || ty > thi) begin
                                s_d.t_bad = 1'b1;
                            end
                        end else if (s_q.t_ent && !s_q.t_bad) begin
                            s_d.tres[31:16] = s_q.trap[1] ? x_in : y_in;
                        end
                    end
                    // thresholds: locate crossing of x or y value RULE_10
                    for (int k = 0; k < 2; k++) begin
                        if (!s_q.th_hit[k] && ((k == 0 ? s_q.thr0[0] : s_q.thr1[0])
                            ? y_in >= (k == 0 ? s_q.thr0[31:16] : s_q.thr1[31:16])
                            : x_in >= (k == 0 ? s_q.thr0[31:16] : s_q.thr1[31:16]))) begin
                            s_d.th_hit[k] = 1'b1;
                            s_d.th_at[k] = (k == 0 ? s_q.thr0[0] : s_q.thr1[0]) ? x_in : y_in;
                        end
                    end
                    // envelope band and turning point RULE_11 RULE_12
                    if (!s_q.first && x_in < s_q.lx) begin
                        s_d.xdir_dn = 1'b1;
                    end
                    if (x_in >= s_q.envx[15:0] && x_in <= s_q.envx[31:16]) begin
                        if (s_q.xdir_dn) begin
                            s_d.env_turn = 1'b1;
                        end
                        if (y_in > s_q.env[31:16] + s_q.env[15:0]
                            || y_in + s_q.env[15:0] < s_q.env[31:16]) begin
                            s_d.env_bad = 1'b1;
                        end
                    end
                end
                // live fail as soon as window violated RULE_05
                if (s_q.win_bad && s_q.wins[9]) begin
                    s_d.live = 1'b1;
                end
                if (stop_hit) begin
                    s_d.st = xyce_pkg::ST_EVAL; // RULE_02
                end
            end
            xyce_pkg::ST_EVAL: begin
                // global verdict over enabled elements RULE_03
                s_d.fail = (s_q.wins[10] && (s_q.win_bad || !s_q.win_ent
                            || (s_q.wins[8] != s_q.in_w)))
                    || (s_q.trap[0] && (s_q.t_bad || !s_q.t_ent))
                    || (s_q.thr0[1] && !s_q.th_hit[0])
                    || (s_q.thr1[1] && !s_q.th_hit[1])
                    || (s_q.env[0] && (s_q.env_bad || s_q.env_turn));
                s_d.rdy = 1'b1;
                s_d.st = xyce_pkg::ST_IDLE;
            end
            default: s_d.st = xyce_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s_q <= '0;
            s_q.st <= xyce_pkg::ST_IDLE;
            s_q.rdy <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // discrete outputs: ready, verdict, live, switching signals RULE_20
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            dout <= '0;
            prdata <= '0;
            pready <= 1'b0;
            pslverr <= 1'b0;
            limit_switch_outputs <= '0;
            live_fail_out <= 1'b0;
            fail_verdict <= 1'b0;
            ready_out <= 1'b0;
        end else begin
            dout <= {prog, s_d.lsw[4:0], s_d.live, s_d.fail & s_d.rdy, s_d.rdy,
                     s_d.st == xyce_pkg::ST_REC};
            prdata <= s_d.rd;
            pready <= s_d.rdy_bus;
            pslverr <= 1'b0;
            limit_switch_outputs <= s_d.lsw;
            live_fail_out <= s_d.live;
            fail_verdict <= s_d.fail;
            ready_out <= s_d.rdy;
        end
    end

    chk_eval_one_cycle: assert property (@(posedge sys_clk) disable iff (rst) // RULE_02
        s_q.st == xyce_pkg::ST_EVAL |=> s_q.st == xyce_pkg::ST_IDLE && ready_out)
        else $error("evaluation did not finish in one cycle");
    chk_rec_not_ready: assert property (@(posedge sys_clk) disable iff (rst) // RULE_02
        s_q.st == xyce_pkg::ST_REC |=> !ready_out)
        else $error("ready shown while recording");
    chk_live_clear: assert property (@(posedge sys_clk) disable iff (rst) // RULE_22
        s_q.st == xyce_pkg::ST_IDLE ##1 s_q.st == xyce_pkg::ST_REC |-> !live_fail_out)
        else $error("live fail not cleared at start");
    chk_live_set: assert property (@(posedge sys_clk) disable iff (rst) // RULE_05
        s_q.st == xyce_pkg::ST_REC && s_q.win_bad && s_q.wins[9] |=> ##1 live_fail_out)
        else $error("live fail missed violation");
    chk_store_count: assert property (@(posedge sys_clk) disable iff (rst) // RULE_01
        mem_we |=> s_q.cnt == $past(s_q.cnt) + 1'b1)
        else $error("sample count not advanced");
    chk_limit_follow: assert property (@(posedge sys_clk) disable iff (rst) // RULE_21
        sample_vld |=> ##1 limit_switch_outputs[0] == (((s_q.lim[0][0] ? $past(y_in, 2)
            : $past(x_in, 2)) > $past(s_q.lim[0][31:16], 2)) ^ $past(s_q.lim[0][1], 2)))
        else $error("limit output mismatch");
    chk_fail_env: assert property (@(posedge sys_clk) disable iff (rst) // RULE_11
        s_q.st == xyce_pkg::ST_EVAL && s_q.env[0] && s_q.env_bad |=> ##1 fail_verdict)
        else $error("envelope violation not failed");
    chk_stop_eval: assert property (@(posedge sys_clk) disable iff (rst) // RULE_16
        s_q.st == xyce_pkg::ST_REC && stop_hit |=> s_q.st == xyce_pkg::ST_EVAL)
        else $error("stop condition ignored");
    chk_start_rec: assert property (@(posedge sys_clk) disable iff (rst) // RULE_15
        s_q.st == xyce_pkg::ST_IDLE && start_hit && s_q.ctrl[0] |=> s_q.st == xyce_pkg::ST_REC)
        else $error("start condition ignored");
    cov_meas: cover property (@(posedge sys_clk) s_q.st == xyce_pkg::ST_EVAL);
    cov_fail: cover property (@(posedge sys_clk) fail_verdict && ready_out);
    cov_live: cover property (@(posedge sys_clk) live_fail_out);
endmodule : xyce_top
